// >>> hw/ufic_fifo.sv
// first-in first-out store with valid/ready on both sides and a run-time capacity limit
// assumes one clock; flush empties the store in one cycle
`timescale 1ns/1ps
module ufic_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH + 1)
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic [CW-1:0] limit,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_inc

  // limit lets the holder shrink to one entry without losing structure
  assign in_ready = (count_ff < limit) && (count_ff < CW'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign count = count_ff;
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else if (flush)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop)
      begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      if (push && !pop)
      begin
        count_ff <= CW'(count_ff + 1'b1);
      end
      else if (pop && !push)
      begin
        count_ff <= CW'(count_ff - 1'b1);
      end
    end
  end
endmodule : ufic_fifo

// >>> hw/ufic_top.sv
// one asynchronous serial channel: holding registers, fifos, start check, masks and ready pins
// assumes a host bus synchronous to clock with one-cycle read and write strobes; 8N1 framing
`timescale 1ns/1ps
`include "ufic_consts.svh"
module ufic_top
#(
  parameter int FIFO_DEPTH = 16,
  parameter int BAUD_DIV = 16,
  parameter bit PD_SUPPORT = 1'b1
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic host_cs_n,
  input wire ufic_pkg::ufic_addr_t host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire ufic_pkg::ufic_byte_t host_data_in,
  output ufic_pkg::ufic_byte_t host_data_out,
  output logic host_data_oe,
  input wire logic serial_rx,
  output logic serial_tx,
  output logic interrupt_out,
  output logic transmit_ready_n,
  output logic receive_ready_n,
  output logic power_down
);
  import ufic_pkg::*;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [15:0] START_CLKS = 16'((`UFIC_START_HALF * BAUD_DIV) / 2);
  localparam logic [15:0] DIV_LAST = 16'(BAUD_DIV - 1);

  logic rst_sync1_ff, rst_sync_ff;
  logic [15:0] div_cnt_ff;
  logic tick;
  logic rx_meta_ff, rx_s2_ff, rx_s3_ff, rx_line_ff, rx_prev_ff;
  ufic_rx_state_t rx_state_ff;
  logic [15:0] rx_clk_cnt_ff;
  logic [3:0] rx_tick_ff;
  logic [2:0] rx_bit_ff;
  ufic_byte_t rx_shift_ff;
  logic rx_push_ff;
  logic [8:0] rx_push_data_ff;
  ufic_tx_state_t tx_state_ff;
  logic [3:0] tx_tick_ff;
  logic [2:0] tx_bit_ff;
  ufic_byte_t tx_shift_ff;
  logic serial_tx_ff;
  ufic_byte_t imask_ff, mctl_ff;
  logic fifo_en_ff, dma_mode_ff;
  logic [1:0] trig_sel_ff;
  logic overrun_ff, data_err_ff, tx_arm_ff, thre_prev_ff, rx_rdy_act_ff;
  logic [9:0] to_cnt_ff;
  ufic_byte_t host_data_out_ff;
  logic host_data_oe_ff, irq_ff, transmit_ready_n_n_ff, receive_ready_n_n_ff, pd_ff;
  logic wr, rd, wr_data, rd_data, wr_fctl, rd_lstat, rd_istat, rx_flush, tx_flush;
  logic skid_ready, skid_valid, rxf_ready, rxf_valid, txf_valid, txf_ready;
  logic [8:0] skid_data, rxf_data;
  ufic_byte_t txf_data;
  logic [CW-1:0] rx_count, tx_count, hold_limit, trig_level;
  logic thre, temt, frame_err, trig_hit, rx_timeout, mode1;
  logic [3:0] isr_code;
  ufic_byte_t lstat, istat, rd_value;

  function automatic logic [CW-1:0] trig_decode(input logic [1:0] sel);
    case (sel)
      2'h0: trig_decode = CW'(`UFIC_TRIG_01);
      2'h1: trig_decode = CW'(`UFIC_TRIG_04);
      2'h2: trig_decode = CW'(`UFIC_TRIG_08);
      default: trig_decode = CW'(`UFIC_TRIG_14);
    endcase
  endfunction : trig_decode

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sync1_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_sync1_ff <= 1'b1;
      rst_sync_ff <= rst_sync1_ff;
    end
  end

  // 16x tick from the system clock
  always_ff @(posedge clock or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      div_cnt_ff <= '0;
    end
    else
    begin
      div_cnt_ff <= tick ? '0 : 16'(div_cnt_ff + 1'b1);
    end
  end
  assign tick = (div_cnt_ff == DIV_LAST);

  assign wr = !host_cs_n && host_wr;
  assign rd = !host_cs_n && host_rd;
  assign wr_data = wr && (host_addr == `UFIC_ADDR_DATA);
  assign rd_data = rd && (host_addr == `UFIC_ADDR_DATA);
  assign wr_fctl = wr && (host_addr == `UFIC_ADDR_FCTL);
  assign rd_istat = rd && (host_addr == `UFIC_ADDR_FCTL);
  assign rd_lstat = rd && (host_addr == `UFIC_ADDR_LSTAT);
  assign rx_flush = wr_fctl && host_data_in[`UFIC_FC_EN] && host_data_in[`UFIC_FC_RXCLR];
  assign tx_flush = wr_fctl && host_data_in[`UFIC_FC_EN] && host_data_in[`UFIC_FC_TXCLR];

  // serial input: only the second stage reads the first
  always_ff @(posedge clock or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      rx_meta_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_s3_ff <= 1'b1;
      rx_line_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end
    else
    begin
      rx_meta_ff <= serial_rx;
      rx_s2_ff <= rx_meta_ff;
      rx_s3_ff <= rx_s2_ff;
      if (rx_s2_ff == rx_s3_ff)
      begin
        rx_line_ff <= rx_s3_ff;
      end
      rx_prev_ff <= rx_line_ff;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      rx_state_ff <= UFIC_RX_IDLE;
      rx_clk_cnt_ff <= '0;
      rx_tick_ff <= '0;
      rx_bit_ff <= '0;
      rx_shift_ff <= '0;
      rx_push_ff <= 1'b0;
      rx_push_data_ff <= '0;
    end
    else
    begin
      rx_push_ff <= 1'b0;
      case (rx_state_ff)
        UFIC_RX_IDLE:
        begin
          rx_clk_cnt_ff <= '0;
          if (rx_prev_ff && !rx_line_ff)
          begin
            rx_state_ff <= UFIC_RX_START;
          end
        end
        UFIC_RX_START:
        begin
          rx_clk_cnt_ff <= 16'(rx_clk_cnt_ff + 1'b1);
          if (rx_clk_cnt_ff == START_CLKS)
          begin
            rx_state_ff <= rx_line_ff ? UFIC_RX_IDLE : UFIC_RX_DATA;
            rx_tick_ff <= '0;
            rx_bit_ff <= '0;
          end
        end
        UFIC_RX_DATA:
        begin
          if (tick)
          begin
            rx_tick_ff <= 4'(rx_tick_ff + 1'b1);
            if (rx_tick_ff == `UFIC_TICK_LAST)
            begin
              rx_shift_ff <= {rx_line_ff, rx_shift_ff[7:1]};
              rx_bit_ff <= 3'(rx_bit_ff + 1'b1);
              if (rx_bit_ff == `UFIC_LAST_BIT)
              begin
                rx_state_ff <= UFIC_RX_STOP;
              end
            end
          end
        end
        default:
        begin
          if (tick)
          begin
            rx_tick_ff <= 4'(rx_tick_ff + 1'b1);
            if (rx_tick_ff == `UFIC_TICK_LAST)
            begin
              rx_push_ff <= 1'b1;
              rx_push_data_ff <= {!rx_line_ff, rx_shift_ff};
              rx_state_ff <= UFIC_RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // two-entry buffer absorbs a host stall on the receive store
  ufic_fifo #(.WIDTH(9), .DEPTH(2)) u_skid (
    .clock(clock), .rst_n(rst_sync_ff), .flush(1'b0), .limit(2'h2),
    .in_valid(rx_push_ff), .in_ready(skid_ready), .in_data(rx_push_data_ff),
    .out_valid(skid_valid), .out_ready(rxf_ready), .out_data(skid_data), .count()
  );
  assign hold_limit = fifo_en_ff ? CW'(FIFO_DEPTH) : CW'(1);
  ufic_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clock(clock), .rst_n(rst_sync_ff), .flush(rx_flush), .limit(hold_limit),
    .in_valid(skid_valid), .in_ready(rxf_ready), .in_data(skid_data),
    .out_valid(rxf_valid), .out_ready(rd_data), .out_data(rxf_data), .count(rx_count)
  );
  ufic_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clock(clock), .rst_n(rst_sync_ff), .flush(tx_flush), .limit(hold_limit),
    .in_valid(wr_data), .in_ready(), .in_data(host_data_in),
    .out_valid(txf_valid), .out_ready(txf_ready), .out_data(txf_data), .count(tx_count)
  );
  assign txf_ready = (tx_state_ff == UFIC_TX_IDLE);

  always_ff @(posedge clock or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      tx_state_ff <= UFIC_TX_IDLE;
      tx_tick_ff <= '0;
      tx_bit_ff <= '0;
      tx_shift_ff <= '0;
      serial_tx_ff <= 1'b1;
    end
    else
    begin
      if (tick && tx_state_ff != UFIC_TX_IDLE)
      begin
        tx_tick_ff <= 4'(tx_tick_ff + 1'b1);
      end
      case (tx_state_ff)
        UFIC_TX_IDLE:
        begin
          if (txf_valid)
          begin
            tx_shift_ff <= txf_data;
            serial_tx_ff <= 1'b0;
            tx_tick_ff <= '0;
            tx_state_ff <= UFIC_TX_START;
          end
        end
        UFIC_TX_START:
        begin
          if (tick && tx_tick_ff == `UFIC_TICK_LAST)
          begin
            serial_tx_ff <= tx_shift_ff[0];
            tx_bit_ff <= '0;
            tx_state_ff <= UFIC_TX_DATA;
          end
        end
        UFIC_TX_DATA:
        begin
          if (tick && tx_tick_ff == `UFIC_TICK_LAST)
          begin
            tx_bit_ff <= 3'(tx_bit_ff + 1'b1);
            tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
            serial_tx_ff <= (tx_bit_ff == `UFIC_LAST_BIT) ? 1'b1 : tx_shift_ff[1];
            if (tx_bit_ff == `UFIC_LAST_BIT)
            begin
              tx_state_ff <= UFIC_TX_STOP;
            end
          end
        end
        default:
        begin
          if (tick && tx_tick_ff == `UFIC_TICK_LAST)
          begin
            tx_state_ff <= UFIC_TX_IDLE;
          end
        end
      endcase
    end
  end

  // host-written control
  always_ff @(posedge clock or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      imask_ff <= `UFIC_IM_RESET;
      mctl_ff <= '0;
      fifo_en_ff <= 1'b0;
      dma_mode_ff <= 1'b0;
      trig_sel_ff <= '0;
    end
    else
    begin
      if (wr && host_addr == `UFIC_ADDR_IMASK)
      begin
        imask_ff <= host_data_in & `UFIC_IM_WMASK & ~(8'(!PD_SUPPORT) << `UFIC_IM_PD);
      end
      if (wr && host_addr == `UFIC_ADDR_MCTL)
      begin
        mctl_ff <= host_data_in & `UFIC_MC_WMASK;
      end
      if (wr_fctl)
      begin
        fifo_en_ff <= host_data_in[`UFIC_FC_EN];
        if (host_data_in[`UFIC_FC_EN])
        begin
          dma_mode_ff <= host_data_in[`UFIC_FC_MODE];
          trig_sel_ff <= host_data_in[`UFIC_FC_TRIG_HI:`UFIC_FC_TRIG_LO];
        end
      end
    end
  end

  assign mode1 = fifo_en_ff && dma_mode_ff;
  assign trig_level = trig_decode(trig_sel_ff);
  assign trig_hit = fifo_en_ff ? (rx_count >= trig_level) : (rx_count != '0);
  assign rx_timeout = fifo_en_ff && (rx_count != '0) && (to_cnt_ff == `UFIC_TIMEOUT_TICKS);
  assign thre = (tx_count == '0);
  assign temt = thre && (tx_state_ff == UFIC_TX_IDLE);
  assign frame_err = rxf_valid && rxf_data[8];
  // line status layout; parity and break unused with fixed framing
  assign lstat = {fifo_en_ff && data_err_ff, temt, thre, 1'b0, frame_err, 1'b0, overrun_ff, rx_count != '0};

  // status flags: a set in the clearing cycle wins
  always_ff @(posedge clock or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      overrun_ff <= 1'b0;
      data_err_ff <= 1'b0;
      tx_arm_ff <= 1'b0;
      thre_prev_ff <= 1'b0;
      to_cnt_ff <= '0;
      rx_rdy_act_ff <= 1'b0;
    end
    else
    begin
      overrun_ff <= (rx_push_ff && !skid_ready) || (overrun_ff && !rd_lstat);
      data_err_ff <= (skid_valid && rxf_ready && skid_data[8]) || (data_err_ff && !rd_lstat);
      thre_prev_ff <= thre;
      tx_arm_ff <= (thre && !thre_prev_ff) || (tx_arm_ff && !wr_data && !(rd_istat && isr_code == `UFIC_IS_TX));
      if ((skid_valid && rxf_ready) || rd_data || rx_count == '0)
      begin
        to_cnt_ff <= '0;
      end
      else if (tick && to_cnt_ff != `UFIC_TIMEOUT_TICKS)
      begin
        to_cnt_ff <= 10'(to_cnt_ff + 1'b1);
      end
      rx_rdy_act_ff <= trig_hit || rx_timeout || (rx_rdy_act_ff && rx_count != '0);
    end
  end

  // receive interrupt follows trigger; gated by mask bit 0; line status by bit 2
  always_comb
  begin
    if (imask_ff[`UFIC_IM_LS] && (overrun_ff || frame_err))
    begin
      isr_code = `UFIC_IS_LS;
    end
    else if (imask_ff[`UFIC_IM_RX] && trig_hit)
    begin
      isr_code = `UFIC_IS_RX;
    end
    else if (imask_ff[`UFIC_IM_RX] && rx_timeout)
    begin
      isr_code = `UFIC_IS_TO;
    end
    else if (imask_ff[`UFIC_IM_TX] && tx_arm_ff)
    begin
      isr_code = `UFIC_IS_TX;
    end
    else
    begin
      isr_code = `UFIC_IS_NONE;
    end
  end
  assign istat = {fifo_en_ff, fifo_en_ff, 2'h0, isr_code};

  always_comb
  begin
    if (host_addr == `UFIC_ADDR_DATA)
    begin
      rd_value = rxf_data[7:0];
    end
    else if (host_addr == `UFIC_ADDR_IMASK)
    begin
      rd_value = imask_ff;
    end
    else if (host_addr == `UFIC_ADDR_FCTL)
    begin
      rd_value = istat;
    end
    else if (host_addr == `UFIC_ADDR_MCTL)
    begin
      rd_value = mctl_ff;
    end
    else if (host_addr == `UFIC_ADDR_LSTAT)
    begin
      rd_value = lstat;
    end
    else
    begin
      rd_value = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      host_data_out_ff <= '0;
      host_data_oe_ff <= 1'b0;
      irq_ff <= 1'b0;
      transmit_ready_n_n_ff <= 1'b0;
      receive_ready_n_n_ff <= 1'b1;
      pd_ff <= 1'b0;
    end
    else
    begin
      if (rd)
      begin
        host_data_out_ff <= rd_value;
      end
      host_data_oe_ff <= rd;
      irq_ff <= (isr_code != `UFIC_IS_NONE);
      transmit_ready_n_n_ff <= mode1 ? (tx_count == CW'(FIFO_DEPTH)) : (tx_count != '0);
      receive_ready_n_n_ff <= mode1 ? !rx_rdy_act_ff : (rx_count == '0);
      pd_ff <= PD_SUPPORT && imask_ff[`UFIC_IM_PD] && mctl_ff[`UFIC_MC_PD];
    end
  end

  assign host_data_out = host_data_out_ff;
  assign host_data_oe = host_data_oe_ff;
  assign serial_tx = serial_tx_ff;
  assign interrupt_out = irq_ff;
  assign transmit_ready_n = transmit_ready_n_n_ff;
  assign receive_ready_n = receive_ready_n_n_ff;
  assign power_down = pd_ff;
endmodule : ufic_top

// >>> shared/ufic_consts.svh
// register addresses, field positions, reset values and timing counts of the serial channel
// assumes an 8-bit host bus with a 3-bit register address
`ifndef UFIC_CONSTS_SVH
`define UFIC_CONSTS_SVH
`define UFIC_ADDR_DATA 3'h0
`define UFIC_ADDR_IMASK 3'h1
`define UFIC_ADDR_FCTL 3'h2
`define UFIC_ADDR_MCTL 3'h4
`define UFIC_ADDR_LSTAT 3'h5
`define UFIC_IM_RX 0
`define UFIC_IM_TX 1
`define UFIC_IM_LS 2
`define UFIC_IM_PD 5
`define UFIC_IM_WMASK 8'h2f
`define UFIC_IM_RESET 8'h00
`define UFIC_FC_EN 0
`define UFIC_FC_RXCLR 1
`define UFIC_FC_TXCLR 2
`define UFIC_FC_MODE 3
`define UFIC_FC_TRIG_LO 6
`define UFIC_FC_TRIG_HI 7
`define UFIC_MC_PD 7
`define UFIC_MC_WMASK 8'h9f
`define UFIC_TRIG_01 5'h01
`define UFIC_TRIG_04 5'h04
`define UFIC_TRIG_08 5'h08
`define UFIC_TRIG_14 5'h0e
`define UFIC_IS_NONE 4'h1
`define UFIC_IS_LS 4'h6
`define UFIC_IS_RX 4'h4
`define UFIC_IS_TO 4'hc
`define UFIC_IS_TX 4'h2
`define UFIC_TICK_LAST 4'hf
`define UFIC_LAST_BIT 3'h7
`define UFIC_START_HALF 15
`define UFIC_TIMEOUT_TICKS 10'h280
`endif

// >>> shared/ufic_pkg.sv
// types shared by the serial channel design files
// assumes the constants header is included by the top design file; the fifo file does not include it
package ufic_pkg;
  typedef logic [7:0] ufic_byte_t;
  typedef logic [2:0] ufic_addr_t;
  typedef enum logic [1:0] {UFIC_RX_IDLE, UFIC_RX_START, UFIC_RX_DATA, UFIC_RX_STOP} ufic_rx_state_t;
  typedef enum logic [1:0] {UFIC_TX_IDLE, UFIC_TX_START, UFIC_TX_DATA, UFIC_TX_STOP} ufic_tx_state_t;
endpackage : ufic_pkg

// >>> tb/uart_fifo_irq_dma_control_tb.sv
// bench for the serial channel: host register sequences against a remote serial device
// assumes the checker bind and the remote model are compiled first
`timescale 1ns/1ps
`include "ufic_consts.svh"
module uart_fifo_irq_dma_control_tb;
  import ufic_pkg::*;
  localparam int BITC = 64;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic host_cs_n = 1'b1;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  ufic_addr_t host_addr = 3'h0;
  ufic_byte_t host_data_in = 8'h00;
  ufic_byte_t host_data_out;
  logic host_data_oe, serial_rx, serial_tx, interrupt_out, transmit_ready_n, receive_ready_n, power_down;
  int failures = 0;
  int n_checks = 0;
  int trig[4] = '{1, 4, 8, 14};
  ufic_top #(.FIFO_DEPTH(16), .BAUD_DIV(4), .PD_SUPPORT(1'b1)) u_dut (.clock(clock), .rstn(rstn),
    .host_cs_n(host_cs_n), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .serial_rx(serial_rx), .serial_tx(serial_tx),
    .interrupt_out(interrupt_out), .transmit_ready_n(transmit_ready_n), .receive_ready_n(receive_ready_n),
    .power_down(power_down));
  ufic_remote #(.BIT_CLKS(BITC)) u_remote (.clock(clock), .serial_rx(serial_rx), .serial_tx(serial_tx));
  initial forever #2 clock = ~clock;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // strobe held one cycle, then one idle cycle so strobes never collide
  task automatic wr(input ufic_addr_t a, input ufic_byte_t d);
    host_cs_n = 1'b0;
    host_addr = a;
    host_data_in = d;
    host_wr = 1'b1;
    @(negedge clock);
    host_cs_n = 1'b1;
    host_wr = 1'b0;
    @(negedge clock);
  endtask : wr
  task automatic rdc(input ufic_addr_t a, input ufic_byte_t m, input ufic_byte_t e, input string what);
    host_cs_n = 1'b0;
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clock);
    host_cs_n = 1'b1;
    host_rd = 1'b0;
    @(negedge clock);
    check(what, host_data_out & m, e);
  endtask : rdc
  task automatic wait_tx(input int n);
    for (int k = 0; k < 2000 && u_remote.got_q.size() < n; k++)
      @(negedge clock);
  endtask : wait_tx
  initial
  begin
    repeat (40000) @(posedge clock);
    failures++;
    $display("watchdog expired");
    give_verdict();
  end
  initial
  begin
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    rdc(`UFIC_ADDR_IMASK, 8'hff, 8'h00, "mask reset");
    rdc(`UFIC_ADDR_LSTAT, 8'hff, 8'h60, "status reset");
    rdc(`UFIC_ADDR_FCTL, 8'hff, 8'h01, "isr reset");
    check("tx ready idle", 8'(transmit_ready_n), 8'h00);
    $display("test reset done");
    wr(`UFIC_ADDR_IMASK, 8'hff);
    rdc(`UFIC_ADDR_IMASK, 8'hff, 8'h2f, "mask unused");
    wr(`UFIC_ADDR_MCTL, 8'h80);
    repeat (3) @(negedge clock);
    check("power down on", 8'(power_down), 8'h01);
    rdc(`UFIC_ADDR_IMASK, 8'h20, 8'h20, "pd mask bit");
    wr(`UFIC_ADDR_IMASK, 8'h0f);
    repeat (3) @(negedge clock);
    check("power down off", 8'(power_down), 8'h00);
    wr(`UFIC_ADDR_IMASK, 8'h00);
    wr(`UFIC_ADDR_MCTL, 8'h00);
    $display("test masks done");
    wr(`UFIC_ADDR_DATA, 8'h5a);
    wr(`UFIC_ADDR_DATA, 8'hc3);
    wr(`UFIC_ADDR_DATA, 8'h99);
    check("tx ready loaded", 8'(transmit_ready_n), 8'h01);
    rdc(`UFIC_ADDR_LSTAT, 8'h60, 8'h00, "tx busy");
    wait_tx(2);
    repeat (2 * BITC) @(negedge clock);
    check("tx count", 8'(u_remote.got_q.size()), 8'h02);
    check("tx first", u_remote.got_q[0], 8'h5a);
    check("tx second", u_remote.got_q[1], 8'hc3);
    rdc(`UFIC_ADDR_LSTAT, 8'h60, 8'h60, "tx empty");
    check("tx ready empty", 8'(transmit_ready_n), 8'h00);
    $display("test transmit done");
    u_remote.false_start();
    repeat (10 * BITC) @(negedge clock);
    rdc(`UFIC_ADDR_LSTAT, 8'h01, 8'h00, "false start");
    u_remote.send_byte(8'ha5);
    rdc(`UFIC_ADDR_LSTAT, 8'h01, 8'h01, "data ready");
    check("rx ready set", 8'(receive_ready_n), 8'h00);
    rdc(`UFIC_ADDR_DATA, 8'hff, 8'ha5, "rx byte");
    rdc(`UFIC_ADDR_LSTAT, 8'h01, 8'h00, "data gone");
    check("rx ready clear", 8'(receive_ready_n), 8'h01);
    $display("test receive done");
    wr(`UFIC_ADDR_FCTL, 8'hc8);
    rdc(`UFIC_ADDR_FCTL, 8'hc0, 8'h00, "fifo gate");
    wr(`UFIC_ADDR_IMASK, 8'h01);
    for (int t = 0; t < 4; t++)
    begin
      wr(`UFIC_ADDR_FCTL, 8'(t << 6) | 8'h0b);
      for (int i = 0; i < trig[t] - 1; i++)
        u_remote.send_byte(8'h30 + 8'(i));
      check("int below", 8'(interrupt_out), 8'h00);
      check("rx ready below", 8'(receive_ready_n), 8'h01);
      u_remote.send_byte(8'h40);
      check("int at level", 8'(interrupt_out), 8'h01);
      rdc(`UFIC_ADDR_FCTL, 8'hcf, 8'hc4, "isr level");
      check("rx ready level", 8'(receive_ready_n), 8'h00);
      rdc(`UFIC_ADDR_DATA, 8'hff, trig[t] == 1 ? 8'h40 : 8'h30, "head byte");
      repeat (2) @(negedge clock);
      check("int dropped", 8'(interrupt_out), 8'h00);
      check("rx ready held", 8'(receive_ready_n), 8'(trig[t] == 1));
      wr(`UFIC_ADDR_FCTL, 8'(t << 6) | 8'h0b);
      rdc(`UFIC_ADDR_LSTAT, 8'h01, 8'h00, "rx flushed");
      check("rx ready flushed", 8'(receive_ready_n), 8'h01);
    end
    $display("test trigger done");
    u_remote.got_q.delete();
    for (int i = 0; i < 17; i++)
      wr(`UFIC_ADDR_DATA, 8'h60 + 8'(i));
    check("tx ready full", 8'(transmit_ready_n), 8'h01);
    wr(`UFIC_ADDR_FCTL, 8'hcd);
    rdc(`UFIC_ADDR_LSTAT, 8'h60, 8'h20, "tx flushed");
    check("tx ready free", 8'(transmit_ready_n), 8'h00);
    wait_tx(1);
    repeat (3 * BITC) @(negedge clock);
    check("shifter kept", 8'(u_remote.got_q.size()), 8'h01);
    check("shifter byte", u_remote.got_q[0], 8'h60);
    wr(`UFIC_ADDR_IMASK, 8'h02);
    repeat (2) @(negedge clock);
    check("tx int", 8'(interrupt_out), 8'h01);
    rdc(`UFIC_ADDR_FCTL, 8'h0f, 8'h02, "isr tx");
    check("tx int read", 8'(interrupt_out), 8'h00);
    $display("test block mode done");
    wr(`UFIC_ADDR_FCTL, 8'h00);
    wr(`UFIC_ADDR_IMASK, 8'h04);
    for (int i = 0; i < 4; i++)
      u_remote.send_byte(8'h70 + 8'(i));
    rdc(`UFIC_ADDR_FCTL, 8'h0f, 8'h06, "isr line");
    rdc(`UFIC_ADDR_LSTAT, 8'h03, 8'h03, "overrun");
    rdc(`UFIC_ADDR_LSTAT, 8'h02, 8'h00, "overrun read");
    $display("test error status done");
    give_verdict();
  end
endmodule : uart_fifo_irq_dma_control_tb

// >>> tb/ufic_checker.sv
// property checker for the serial channel top, bound by name to its ports
// assumes one clock and one-cycle host strobes
`timescale 1ns/1ps
`include "ufic_consts.svh"
module ufic_checker
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic host_cs_n,
  input wire ufic_pkg::ufic_addr_t host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire ufic_pkg::ufic_byte_t host_data_in,
  input wire ufic_pkg::ufic_byte_t host_data_out,
  input wire logic host_data_oe,
  input wire logic serial_rx,
  input wire logic serial_tx,
  input wire logic interrupt_out,
  input wire logic transmit_ready_n,
  input wire logic receive_ready_n,
  input wire logic power_down
);
  import ufic_pkg::*;
  logic en_ff;
  logic mode_ff;
  logic [3:0] mask_ff;
  logic rd_s;
  logic wr_s;
  assign rd_s = !host_cs_n && host_rd;
  assign wr_s = !host_cs_n && host_wr;
  // shadow of enable and mode; a write without the enable bit keeps the old mode
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      en_ff <= 1'b0;
    else if (wr_s && host_addr == `UFIC_ADDR_FCTL)
      en_ff <= host_data_in[0];
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      mode_ff <= 1'b0;
    else if (wr_s && host_addr == `UFIC_ADDR_FCTL && host_data_in[0])
      mode_ff <= host_data_in[3];
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      mask_ff <= 4'h0;
    else if (wr_s && host_addr == `UFIC_ADDR_IMASK)
      mask_ff <= host_data_in[3:0];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  rst_vals_a:
  assert property ($rose(rstn) |-> serial_tx && !interrupt_out && receive_ready_n && !transmit_ready_n && !power_down)
    else $error("outputs not at reset levels");
  oe_pulse_a:
  assert property (rd_s |=> host_data_oe) else $error("bus not driven after read");
  oe_idle_a:
  assert property (!rd_s |=> !host_data_oe) else $error("bus driven without read");
  imask_unused_a:
  assert property (rd_s && host_addr == `UFIC_ADDR_IMASK |=> host_data_out[7:6] == 2'h0 && !host_data_out[4])
    else $error("unused mask bits read nonzero");
  pwr_mask_a:
  assert property (rd_s && host_addr == `UFIC_ADDR_IMASK && power_down |=> host_data_out[5])
    else $error("power down without mask bit");
  isr_fifo_a:
  assert property (rd_s && host_addr == `UFIC_ADDR_FCTL |=> host_data_out[7:6] == {2{en_ff}} && host_data_out[5:4] == 2'h0)
    else $error("status fifo bits wrong");
  receive_ready_n_lsr_a:
  assert property ((!en_ff || !mode_ff) && rd_s && host_addr == `UFIC_ADDR_LSTAT && $stable(receive_ready_n)
    ##1 $stable(receive_ready_n) |-> host_data_out[0] == !receive_ready_n) else $error("ready pin and data bit differ");
  int_masked_a:
  assert property (mask_ff == 4'h0 && $past(mask_ff) == 4'h0 && $past(mask_ff, 2) == 4'h0 |-> !interrupt_out)
    else $error("interrupt while masked");
endmodule : ufic_checker
bind ufic_top ufic_checker u_chk (.clock(clock), .rstn(rstn), .host_cs_n(host_cs_n), .host_addr(host_addr),
  .host_wr(host_wr), .host_rd(host_rd), .host_data_in(host_data_in), .host_data_out(host_data_out),
  .host_data_oe(host_data_oe), .serial_rx(serial_rx), .serial_tx(serial_tx), .interrupt_out(interrupt_out),
  .transmit_ready_n(transmit_ready_n), .receive_ready_n(receive_ready_n), .power_down(power_down));

// >>> tb/ufic_remote.sv
// remote serial device: sends 8N1 frames and collects frames from the transmit line
// assumes bit time in clocks equals sixteen ticks of the channel
`timescale 1ns/1ps
module ufic_remote
#(
  parameter int BIT_CLKS = 64
)
(
  input wire logic clock,
  output logic serial_rx,
  input wire logic serial_tx
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  initial serial_rx = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      serial_rx <= f[i];
      repeat (BIT_CLKS) @(negedge clock);
    end
  endtask : send_byte
  // short low pulse, well under half a bit, so it must be refused
  task automatic false_start();
    serial_rx <= 1'b0;
    repeat (BIT_CLKS / 4) @(negedge clock);
    serial_rx <= 1'b1;
  endtask : false_start
  always
  begin
    @(negedge serial_tx);
    repeat (BIT_CLKS / 2) @(posedge clock);
    if (serial_tx === 1'b0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CLKS) @(posedge clock);
        sh[i] = serial_tx;
      end
      repeat (BIT_CLKS) @(posedge clock);
      got_q.push_back(sh);
    end
  end
endmodule : ufic_remote
